// file: design/tcap_pkg.sv
// Constants, register map and carrier types of the input capture timer channel
package tcap_pkg;

  // ----------------------------------------------------------------
  // Bus widths
  // ----------------------------------------------------------------
  localparam int ADDR_W = 8;
  localparam int DATA_W = 8;

  typedef logic [DATA_W-1:0] tcap_byte_t;

  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    tcap_byte_t        wdata;
    logic              wr;
    logic              rd;
  } tcap_bus_req_s;

  typedef struct packed {
    logic ovf;
    logic cap_c;
    logic cap_a;
  } tcap_evt_s;

  // ----------------------------------------------------------------
  // Register offsets
  // ----------------------------------------------------------------
  localparam logic [ADDR_W-1:0] OFS_PFM    = 8'h00;
  localparam logic [ADDR_W-1:0] OFS_ILVL   = 8'h01;
  localparam logic [ADDR_W-1:0] OFS_MODULE_STANDBY_CONTROL  = 8'h02;
  localparam logic [ADDR_W-1:0] OFS_MODE   = 8'h03;
  localparam logic [ADDR_W-1:0] OFS_CCR1   = 8'h04;
  localparam logic [ADDR_W-1:0] OFS_IOR0   = 8'h05;
  localparam logic [ADDR_W-1:0] OFS_IOR1   = 8'h06;
  localparam logic [ADDR_W-1:0] OFS_CNT_LO = 8'h08;
  localparam logic [ADDR_W-1:0] OFS_CNT_HI = 8'h09;
  localparam logic [ADDR_W-1:0] OFS_GRA_LO = 8'h0A;
  localparam logic [ADDR_W-1:0] OFS_GRA_HI = 8'h0B;
  localparam logic [ADDR_W-1:0] OFS_GRC_LO = 8'h0C;
  localparam logic [ADDR_W-1:0] OFS_GRC_HI = 8'h0D;
  localparam logic [ADDR_W-1:0] OFS_STAT   = 8'h10;
  localparam logic [ADDR_W-1:0] OFS_ICLR   = 8'h11;
  localparam logic [ADDR_W-1:0] OFS_IEN    = 8'h12;

  // ----------------------------------------------------------------
  // Field positions and codes
  // ----------------------------------------------------------------
  localparam int PFM_SEL_LO    = 2;
  localparam int PFM_SEL_HI    = 3;
  localparam logic [1:0] PFM_ROUTE_CAP = 2'h1;
  localparam int ILVL_LO       = 4;
  localparam int ILVL_HI       = 5;
  localparam logic [1:0] LVL_OFF = 2'h0;
  localparam int MST_SLEEP_BIT = 5;
  localparam int MODE_DUAL_BIT = 3;
  localparam int MODE_BUF_BIT  = 4;
  localparam int MODE_RUN_BIT  = 7;
  localparam int CCR1_SRC_LO   = 4;
  localparam int CCR1_SRC_HI   = 6;
  localparam int CCR1_CLR_BIT  = 7;
  localparam logic [2:0] SRC_UNDIV = 3'h0;
  localparam logic [2:0] SRC_DIV2  = 3'h1;
  localparam logic [2:0] SRC_DIV4  = 3'h2;
  localparam logic [2:0] SRC_DIV8  = 3'h3;
  localparam logic [2:0] SRC_DIV32 = 3'h4;
  localparam int IOR_EDGE_LO   = 0;
  localparam int IOR_EDGE_HI   = 1;
  localparam int IOR_CAP_BIT   = 2;
  localparam logic [1:0] EDGE_RISE = 2'h0;
  localparam logic [1:0] EDGE_FALL = 2'h1;
  localparam int ST_CAP_A      = 0;
  localparam int ST_CAP_C      = 2;
  localparam int ST_OVF        = 7;
  localparam int PRESC_W       = 5;

  // ----------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------
  localparam tcap_byte_t RST_ZERO  = 8'h00;
  localparam tcap_byte_t RST_MODULE_STANDBY_CONTROL = 8'h20;

endpackage

// file: design/tcap_top.sv
// Input capture timer channel with byte register port and level interrupt
`timescale 1ns/1ps
module tcap_top #(
  parameter int CNT_W = 16
) (
  // Clock and reset
  input  wire logic                  ref_clk,
  input  wire logic                  srst,
  // Register port
  input  wire tcap_pkg::tcap_bus_req_s bus_req,
  output logic [tcap_pkg::DATA_W-1:0] rd_data,
  // Pins
  input  wire logic                  port1_pin1,
  input  wire logic                  capture_pin_c,
  // Interrupt
  output logic                       irq
);

  // ----------------------------------------------------------------
  // Elaboration checks
  // ----------------------------------------------------------------
  if (CNT_W != 2 * tcap_pkg::DATA_W) begin : g_bad_width
    $error("CNT_W must be two register bytes wide");
  end

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  function automatic logic edge_hit(input logic [1:0] sel,
                                    input logic       rise,
                                    input logic       fall);
    logic hit;
    unique case (sel)
      tcap_pkg::EDGE_RISE: hit = rise;
      tcap_pkg::EDGE_FALL: hit = fall;
      default:             hit = rise | fall;
    endcase
    return hit;
  endfunction

  function automatic logic src_tick(input logic [2:0] sel,
                                    input logic [tcap_pkg::PRESC_W-1:0] pc);
    logic t;
    unique case (sel)
      tcap_pkg::SRC_UNDIV: t = 1'b1;
      tcap_pkg::SRC_DIV2:  t = &pc[0:0];
      tcap_pkg::SRC_DIV4:  t = &pc[1:0];
      tcap_pkg::SRC_DIV8:  t = &pc[2:0];
      tcap_pkg::SRC_DIV32: t = &pc[4:0];
      default:             t = 1'b0;
    endcase
    return t;
  endfunction

  // ----------------------------------------------------------------
  // Pin synchronisers
  // ----------------------------------------------------------------
  localparam int NPIN = 2;
  logic [NPIN-1:0] pin_raw;
  logic [NPIN-1:0] meta_reg;
  logic [NPIN-1:0] sync_reg;
  logic [NPIN-1:0] last_reg;
  logic [NPIN-1:0] rise;
  logic [NPIN-1:0] fall;

  assign pin_raw = {capture_pin_c, port1_pin1};

  // First stage feeds only the second; edges come from stages two and three
  for (genvar i = 0; i < NPIN; i++) begin : g_sync
    always_ff @(posedge ref_clk) begin
      if (srst) begin
        meta_reg[i] <= 1'b0;
        sync_reg[i] <= 1'b0;
        last_reg[i] <= 1'b0;
      end else begin
        meta_reg[i] <= pin_raw[i];
        sync_reg[i] <= meta_reg[i];
        last_reg[i] <= sync_reg[i];
      end
    end
    assign rise[i] = sync_reg[i] & ~last_reg[i];
    assign fall[i] = ~sync_reg[i] & last_reg[i];
  end

  // ----------------------------------------------------------------
  // Register state
  // ----------------------------------------------------------------
  tcap_pkg::tcap_byte_t pfm_reg, pfm_next;
  tcap_pkg::tcap_byte_t ilvl_reg, ilvl_next;
  tcap_pkg::tcap_byte_t mst_reg, mst_next;
  tcap_pkg::tcap_byte_t mode_reg, mode_next;
  tcap_pkg::tcap_byte_t ccr1_reg, ccr1_next;
  tcap_pkg::tcap_byte_t ior0_reg, ior0_next;
  tcap_pkg::tcap_byte_t ior1_reg, ior1_next;
  tcap_pkg::tcap_byte_t stat_reg, stat_next;
  tcap_pkg::tcap_byte_t armed_reg, armed_next;
  tcap_pkg::tcap_byte_t ien_reg, ien_next;
  tcap_pkg::tcap_byte_t rd_data_reg, rd_data_next;
  logic [CNT_W-1:0] cnt_reg, cnt_next;
  logic [CNT_W-1:0] gra_reg, gra_next;
  logic [CNT_W-1:0] grc_reg, grc_next;
  logic [tcap_pkg::PRESC_W-1:0] presc_reg, presc_next;
  logic irq_reg, irq_next;

  // ----------------------------------------------------------------
  // Control decode
  // ----------------------------------------------------------------
  logic active;
  logic timer_mode;
  logic buffered;
  logic running;
  logic tick;
  logic clr_on_cap;
  logic a_cap_en;
  logic c_cap_en;
  logic pin_routed;
  tcap_pkg::tcap_evt_s evt;
  logic wr;
  logic rd;
  logic [tcap_pkg::ADDR_W-1:0] addr;
  tcap_pkg::tcap_byte_t wdat;

  assign wr   = bus_req.wr;
  assign rd   = bus_req.rd;
  assign addr = bus_req.addr;
  assign wdat = bus_req.wdata;

  assign active     = ~mst_reg[tcap_pkg::MST_SLEEP_BIT];
  assign timer_mode = mode_reg[tcap_pkg::MODE_DUAL_BIT];
  assign buffered   = mode_reg[tcap_pkg::MODE_BUF_BIT];
  assign running    = active & mode_reg[tcap_pkg::MODE_RUN_BIT];
  assign tick       = running &
                      src_tick(ccr1_reg[tcap_pkg::CCR1_SRC_HI:tcap_pkg::CCR1_SRC_LO],
                               presc_reg);
  assign clr_on_cap = ccr1_reg[tcap_pkg::CCR1_CLR_BIT];
  assign pin_routed = pfm_reg[tcap_pkg::PFM_SEL_HI:tcap_pkg::PFM_SEL_LO]
                      == tcap_pkg::PFM_ROUTE_CAP;
  assign a_cap_en   = active & timer_mode & pin_routed &
                      ior0_reg[tcap_pkg::IOR_CAP_BIT];
  // Channel C pin is unused while C buffers A
  assign c_cap_en   = active & timer_mode & ~buffered &
                      ior1_reg[tcap_pkg::IOR_CAP_BIT];

  assign evt.cap_a = a_cap_en &
                     edge_hit(ior0_reg[tcap_pkg::IOR_EDGE_HI:tcap_pkg::IOR_EDGE_LO],
                              rise[0], fall[0]);
  assign evt.cap_c = c_cap_en &
                     edge_hit(ior1_reg[tcap_pkg::IOR_EDGE_HI:tcap_pkg::IOR_EDGE_LO],
                              rise[1], fall[1]);
  assign evt.ovf   = tick & (&cnt_reg);

  // Software waits two clocks after control 1 before I/O control 0
  // no write hold-off is kept here.

  // ----------------------------------------------------------------
  // Control registers
  // ----------------------------------------------------------------
  always_comb begin
    pfm_next  = pfm_reg;
    ilvl_next = ilvl_reg;
    mst_next  = mst_reg;
    mode_next = mode_reg;
    ccr1_next = ccr1_reg;
    ior0_next = ior0_reg;
    ior1_next = ior1_reg;
    ien_next  = ien_reg;
    if (wr) begin
      unique case (addr)
        tcap_pkg::OFS_PFM:   pfm_next  = wdat;
        tcap_pkg::OFS_ILVL:  ilvl_next = wdat;
        tcap_pkg::OFS_MODULE_STANDBY_CONTROL: mst_next  = wdat;
        tcap_pkg::OFS_MODE:  mode_next = wdat;
        tcap_pkg::OFS_CCR1:  ccr1_next = wdat;
        tcap_pkg::OFS_IOR0:  ior0_next = wdat;
        tcap_pkg::OFS_IOR1:  ior1_next = wdat;
        tcap_pkg::OFS_IEN:   ien_next  = wdat;
        default: ;
      endcase
    end
  end

  always_ff @(posedge ref_clk) begin
    if (srst) begin
      pfm_reg  <= tcap_pkg::RST_ZERO;
      ilvl_reg <= tcap_pkg::RST_ZERO;
      mst_reg  <= tcap_pkg::RST_MODULE_STANDBY_CONTROL;
      mode_reg <= tcap_pkg::RST_ZERO;
      ccr1_reg <= tcap_pkg::RST_ZERO;
      ior0_reg <= tcap_pkg::RST_ZERO;
      ior1_reg <= tcap_pkg::RST_ZERO;
      ien_reg  <= tcap_pkg::RST_ZERO;
    end else begin
      pfm_reg  <= pfm_next;
      ilvl_reg <= ilvl_next;
      mst_reg  <= mst_next;
      mode_reg <= mode_next;
      ccr1_reg <= ccr1_next;
      ior0_reg <= ior0_next;
      ior1_reg <= ior1_next;
      ien_reg  <= ien_next;
    end
  end

  // ----------------------------------------------------------------
  // Counter and general registers
  // ----------------------------------------------------------------
  always_comb begin
    presc_next = running ? presc_reg + 1'b1 : '0;
    cnt_next   = cnt_reg;
    gra_next   = gra_reg;
    grc_next   = grc_reg;
    if (tick) begin
      cnt_next = cnt_reg + 1'b1;
    end
    if (evt.cap_a) begin
      gra_next = cnt_reg;
      if (buffered) begin
        grc_next = gra_reg;
      end
      if (clr_on_cap) begin
        cnt_next = '0;
      end
    end
    if (evt.cap_c) begin
      grc_next = cnt_reg;
    end
    // Software writes win over hardware updates in the same cycle
    if (wr) begin
      unique case (addr)
        tcap_pkg::OFS_CNT_LO: cnt_next[7:0]  = wdat;
        tcap_pkg::OFS_CNT_HI: cnt_next[15:8] = wdat;
        tcap_pkg::OFS_GRA_LO: gra_next[7:0]  = wdat;
        tcap_pkg::OFS_GRA_HI: gra_next[15:8] = wdat;
        tcap_pkg::OFS_GRC_LO: grc_next[7:0]  = wdat;
        tcap_pkg::OFS_GRC_HI: grc_next[15:8] = wdat;
        default: ;
      endcase
    end
  end

  always_ff @(posedge ref_clk) begin
    if (srst) begin
      presc_reg <= '0;
      cnt_reg   <= '0;
      gra_reg   <= '0;
      grc_reg   <= '0;
    end else begin
      presc_reg <= presc_next;
      cnt_reg   <= cnt_next;
      gra_reg   <= gra_next;
      grc_reg   <= grc_next;
    end
  end

  // ----------------------------------------------------------------
  // Status, clear and interrupt
  // ----------------------------------------------------------------
  tcap_pkg::tcap_byte_t set_bits;
  tcap_pkg::tcap_byte_t clr_bits;

  always_comb begin
    set_bits = '0;
    set_bits[tcap_pkg::ST_CAP_A] = evt.cap_a;
    set_bits[tcap_pkg::ST_CAP_C] = evt.cap_c;
    set_bits[tcap_pkg::ST_OVF]   = evt.ovf;
    clr_bits   = '0;
    armed_next = armed_reg;
    // A read arms each flag seen as 1; a later 0 write clears it
    if (rd && addr == tcap_pkg::OFS_STAT) begin
      armed_next = armed_reg | stat_reg;
    end
    if (wr && addr == tcap_pkg::OFS_STAT) begin
      clr_bits = armed_reg & ~wdat;
    end
    if (wr && addr == tcap_pkg::OFS_ICLR) begin
      clr_bits = clr_bits | wdat;
    end
    // A set in the clearing cycle survives
    stat_next  = (stat_reg & ~clr_bits) | set_bits;
    armed_next = armed_next & ~clr_bits;
    irq_next   = (|(stat_next & ien_reg)) &
                 (ilvl_reg[tcap_pkg::ILVL_HI:tcap_pkg::ILVL_LO]
                  != tcap_pkg::LVL_OFF);
  end

  always_ff @(posedge ref_clk) begin
    if (srst) begin
      stat_reg  <= tcap_pkg::RST_ZERO;
      armed_reg <= tcap_pkg::RST_ZERO;
      irq_reg   <= 1'b0;
    end else begin
      stat_reg  <= stat_next;
      armed_reg <= armed_next;
      irq_reg   <= irq_next;
    end
  end

  // ----------------------------------------------------------------
  // Read port
  // ----------------------------------------------------------------
  always_comb begin
    rd_data_next = '0;
    if (rd) begin
      unique case (addr)
        tcap_pkg::OFS_PFM:    rd_data_next = pfm_reg;
        tcap_pkg::OFS_ILVL:   rd_data_next = ilvl_reg;
        tcap_pkg::OFS_MODULE_STANDBY_CONTROL:  rd_data_next = mst_reg;
        tcap_pkg::OFS_MODE:   rd_data_next = mode_reg;
        tcap_pkg::OFS_CCR1:   rd_data_next = ccr1_reg;
        tcap_pkg::OFS_IOR0:   rd_data_next = ior0_reg;
        tcap_pkg::OFS_IOR1:   rd_data_next = ior1_reg;
        tcap_pkg::OFS_CNT_LO: rd_data_next = cnt_reg[7:0];
        tcap_pkg::OFS_CNT_HI: rd_data_next = cnt_reg[15:8];
        tcap_pkg::OFS_GRA_LO: rd_data_next = gra_reg[7:0];
        tcap_pkg::OFS_GRA_HI: rd_data_next = gra_reg[15:8];
        tcap_pkg::OFS_GRC_LO: rd_data_next = grc_reg[7:0];
        tcap_pkg::OFS_GRC_HI: rd_data_next = grc_reg[15:8];
        tcap_pkg::OFS_STAT:   rd_data_next = stat_reg;
        tcap_pkg::OFS_IEN:    rd_data_next = ien_reg;
        default:              rd_data_next = '0;
      endcase
    end
  end

  always_ff @(posedge ref_clk) begin
    if (srst) begin
      rd_data_reg <= tcap_pkg::RST_ZERO;
    end else begin
      rd_data_reg <= rd_data_next;
    end
  end

  assign rd_data = rd_data_reg;
  assign irq     = irq_reg;

endmodule

// file: dv/tcap_pulse_src.sv
// Pulse source model driving the two capture pins of the timer channel
`timescale 1ns/1ps
module tcap_pulse_src (
  // Clock
  input  wire logic ref_clk,
  // Capture pins
  output logic      pin_a,
  output logic      pin_c
);
  // ----------------------------------------------------------------
  // Pin drivers
  // ----------------------------------------------------------------
  // Levels change just after an edge and stay put for many clocks,
  // so every transition is wide enough for the two-stage synchroniser
  initial begin
    pin_a = 1'b0;
    pin_c = 1'b0;
  end

  task automatic drive_a(input logic v);
    @(posedge ref_clk);
    pin_a <= v;
  endtask

  task automatic drive_c(input logic v);
    @(posedge ref_clk);
    pin_c <= v;
  endtask
endmodule

// file: dv/tcap_top_sva.sv
// Port-level checker for the input capture timer channel
`timescale 1ns/1ps
module tcap_top_chk #(
  parameter int CNT_W = 16
) (
  input wire logic                    ref_clk,
  input wire logic                    srst,
  input wire tcap_pkg::tcap_bus_req_s bus_req,
  input wire logic [7:0]              rd_data,
  input wire logic                    port1_pin1,
  input wire logic                    capture_pin_c,
  input wire logic                    irq
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (srst);

  // ----------------------------------------------------------------
  // Shadows of the interrupt level and enable registers
  // ----------------------------------------------------------------
  logic [1:0] lvl_reg;
  logic [1:0] lvl_next;
  logic [7:0] ien_reg;
  logic [7:0] ien_next;

  always_comb begin
    lvl_next = lvl_reg;
    ien_next = ien_reg;
    if (srst) begin
      lvl_next = 2'h0;
      ien_next = 8'h00;
    end else if (bus_req.wr && bus_req.addr == tcap_pkg::OFS_ILVL) begin
      lvl_next = bus_req.wdata[5:4];
    end else if (bus_req.wr && bus_req.addr == tcap_pkg::OFS_IEN) begin
      ien_next = bus_req.wdata;
    end
  end

  always_ff @(posedge ref_clk) begin
    lvl_reg <= lvl_next;
    ien_reg <= ien_next;
  end

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  reset_quiet_a: assert property (disable iff (1'b0) srst |=> !irq && rd_data == 8'h00)
    else $error("irq or read data not quiet after reset");
  rd_idle_a: assert property (!$past(bus_req.rd) |-> rd_data == 8'h00)
    else $error("read data not zero outside read answer");
  unmapped_zero_a: assert property (bus_req.rd && bus_req.addr == 8'h07 |=> rd_data == 8'h00)
    else $error("unmapped read returned nonzero");
  clear_reg_zero_a: assert property (bus_req.rd && bus_req.addr == tcap_pkg::OFS_ICLR
    |=> rd_data == 8'h00) else $error("clear register read nonzero");
  stat_reserved_a: assert property (bus_req.rd && bus_req.addr == tcap_pkg::OFS_STAT
    |=> rd_data[6:3] == 4'h0 && !rd_data[1]) else $error("status unused bits set");
  cfg_readback_a: assert property (
    (bus_req.wr && bus_req.addr <= tcap_pkg::OFS_IOR1) ##2
    (bus_req.rd && bus_req.addr == $past(bus_req.addr, 2))
    |=> rd_data == $past(bus_req.wdata, 3))
    else $error("control register readback differs");
  level_off_a: assert property (lvl_reg == 2'h0 [*3] |-> !irq)
    else $error("irq raised at priority level zero");
  irq_mask_a: assert property (ien_reg == 8'h00 [*3] |-> !irq)
    else $error("irq raised with all enables clear");
  irq_cause_a: assert property (
    $rose(irq) |-> $past(lvl_reg) != 2'h0 && $past(ien_reg) != 8'h00)
    else $error("irq rose without level and enable");

  irq_rise_c: cover property ($rose(irq));
  stat_read_c: cover property (bus_req.rd && bus_req.addr == tcap_pkg::OFS_STAT);
  clear_wr_c: cover property (bus_req.wr && bus_req.addr == tcap_pkg::OFS_ICLR);
  pin_edge_c: cover property ($changed(port1_pin1) || $changed(capture_pin_c));
endmodule

bind tcap_top tcap_top_chk #(.CNT_W(CNT_W)) tcap_top_chk_inst (
  .ref_clk(ref_clk), .srst(srst), .bus_req(bus_req), .rd_data(rd_data),
  .port1_pin1(port1_pin1), .capture_pin_c(capture_pin_c), .irq(irq));

// file: dv/tcap_top_tb_top.sv
// Self-checking testbench of the input capture timer channel
`timescale 1ns/1ps
module tcap_top_tb_top;
  logic                    ref_clk;
  logic                    srst;
  logic                    irq;
  logic                    pin_a;
  logic                    pin_c;
  tcap_pkg::tcap_bus_req_s bus_req;
  tcap_pkg::tcap_byte_t    rd_data;
  tcap_pkg::tcap_byte_t    v0;
  tcap_pkg::tcap_byte_t    v1;
  logic [7:0]              cfg_a [7];
  tcap_pkg::tcap_byte_t    cfg_v [7];
  logic [7:0]              bad_a [4];
  tcap_pkg::tcap_byte_t    bad_v [4];
  tcap_pkg::tcap_byte_t    good_v [4];
  int                      errors;
  int                      checked;

  tcap_top #(.CNT_W(16)) tcap_top_inst (.ref_clk(ref_clk), .srst(srst), .bus_req(bus_req),
    .rd_data(rd_data), .port1_pin1(pin_a), .capture_pin_c(pin_c), .irq(irq));
  tcap_pulse_src tcap_pulse_src_inst (.ref_clk(ref_clk), .pin_a(pin_a), .pin_c(pin_c));

  initial ref_clk = 1'b0;
  always #2.5 ref_clk = ~ref_clk;

  // ----------------------------------------------------------------
  // Bus and compare tasks
  // ----------------------------------------------------------------
  task automatic check(input tcap_pkg::tcap_byte_t seen, input tcap_pkg::tcap_byte_t exp);
    checked++;
    if (seen !== exp) begin
      errors++;
      $display("wrong value at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic wr(input logic [7:0] a, input tcap_pkg::tcap_byte_t d);
    @(posedge ref_clk);
    bus_req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    @(posedge ref_clk);
    bus_req.wr <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a, output tcap_pkg::tcap_byte_t d);
    @(posedge ref_clk);
    bus_req <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
    @(posedge ref_clk);
    bus_req.rd <= 1'b0;
    #1 d = rd_data;
  endtask

  task automatic rd_chk(input logic [7:0] a, input tcap_pkg::tcap_byte_t exp);
    tcap_pkg::tcap_byte_t d;
    rd(a, d);
    check(d, exp);
  endtask

  task automatic chk_irq(input logic e);
    #1 check({7'h00, irq}, {7'h00, e});
  endtask

  // Capture and irq both land on the third edge after the pin; six leaves margin
  task automatic settle();
    repeat (6) @(posedge ref_clk);
  endtask

  task automatic conclude();
    $display("comparisons %0d mismatches %0d", checked, errors);
    if (errors == 0 && checked > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask

  // Whole run is a few hundred cycles
  initial begin
    #200000;
    errors++;
    conclude();
  end

  // ----------------------------------------------------------------
  // Test sequence
  // ----------------------------------------------------------------
  initial begin
    errors = 0;
    checked = 0;
    bus_req = '0;
    srst = 1'b1;
    cfg_a = '{tcap_pkg::OFS_PFM, tcap_pkg::OFS_ILVL, tcap_pkg::OFS_MODULE_STANDBY_CONTROL, tcap_pkg::OFS_MODE,
              tcap_pkg::OFS_CCR1, tcap_pkg::OFS_IOR0, tcap_pkg::OFS_IOR1};
    cfg_v = '{8'h04, 8'h10, 8'h00, 8'h08, 8'h00, 8'h07, 8'h04};
    bad_a = '{tcap_pkg::OFS_MODULE_STANDBY_CONTROL, tcap_pkg::OFS_PFM, tcap_pkg::OFS_MODE, tcap_pkg::OFS_IOR0};
    bad_v = '{8'h20, 8'h00, 8'h00, 8'h03};
    good_v = '{8'h00, 8'h04, 8'h08, 8'h07};
    repeat (20) @(posedge ref_clk);
    srst <= 1'b0;
    // Reset values, unmapped and write-only places read zero
    for (int i = 0; i <= 17; i++) begin
      rd_chk(8'(i), (i == 2) ? 8'h20 : 8'h00);
    end
    // Upper address bits take part in decode: no alias onto standby control
    wr(8'hE2, 8'hFF);
    rd_chk(8'hE2, 8'h00);
    rd_chk(tcap_pkg::OFS_MODULE_STANDBY_CONTROL, 8'h20);
    chk_irq(1'b0);
    $display("test reset_values done");
    // Capture configuration with readback
    for (int i = 0; i < 7; i++) begin
      if (cfg_a[i] == tcap_pkg::OFS_IOR0) repeat (2) @(posedge ref_clk);
      wr(cfg_a[i], cfg_v[i]);
      rd_chk(cfg_a[i], cfg_v[i]);
    end
    wr(tcap_pkg::OFS_IEN, 8'h05);
    $display("test configure done");
    // Stopped counter holds, running counter ticks every clock and wraps
    wr(tcap_pkg::OFS_CNT_LO, 8'hF0);
    wr(tcap_pkg::OFS_CNT_HI, 8'hFF);
    rd_chk(tcap_pkg::OFS_CNT_LO, 8'hF0);
    rd_chk(tcap_pkg::OFS_CNT_HI, 8'hFF);
    wr(tcap_pkg::OFS_MODE, 8'h88);
    rd(tcap_pkg::OFS_CNT_LO, v0);
    rd(tcap_pkg::OFS_CNT_LO, v1);
    check(8'(v1 - v0), 8'h02);
    repeat (20) @(posedge ref_clk);
    wr(tcap_pkg::OFS_MODE, 8'h08);
    rd_chk(tcap_pkg::OFS_STAT, 8'h80);
    wr(tcap_pkg::OFS_STAT, 8'h7F);
    rd_chk(tcap_pkg::OFS_STAT, 8'h00);
    // Half-rate source advances once across the same two-read span
    wr(tcap_pkg::OFS_CCR1, 8'h10);
    wr(tcap_pkg::OFS_MODE, 8'h88);
    rd(tcap_pkg::OFS_CNT_LO, v0);
    rd(tcap_pkg::OFS_CNT_LO, v1);
    check(8'(v1 - v0), 8'h01);
    wr(tcap_pkg::OFS_MODE, 8'h08);
    wr(tcap_pkg::OFS_CCR1, 8'h00);
    $display("test counter done");
    // Capture on a rising edge, flag clear only after it was read
    wr(tcap_pkg::OFS_CNT_LO, 8'h34);
    wr(tcap_pkg::OFS_CNT_HI, 8'h12);
    tcap_pulse_src_inst.drive_a(1'b1);
    settle();
    rd_chk(tcap_pkg::OFS_GRA_LO, 8'h34);
    rd_chk(tcap_pkg::OFS_GRA_HI, 8'h12);
    rd_chk(tcap_pkg::OFS_CNT_LO, 8'h34);
    chk_irq(1'b1);
    wr(tcap_pkg::OFS_STAT, 8'h00);
    chk_irq(1'b1);
    rd_chk(tcap_pkg::OFS_STAT, 8'h01);
    wr(tcap_pkg::OFS_STAT, 8'h00);
    rd_chk(tcap_pkg::OFS_STAT, 8'h00);
    chk_irq(1'b0);
    // Buffered capture on the falling edge keeps the older value once
    wr(tcap_pkg::OFS_MODE, 8'h18);
    wr(tcap_pkg::OFS_CNT_LO, 8'h55);
    wr(tcap_pkg::OFS_CNT_HI, 8'h00);
    tcap_pulse_src_inst.drive_a(1'b0);
    settle();
    rd_chk(tcap_pkg::OFS_GRA_LO, 8'h55);
    rd_chk(tcap_pkg::OFS_GRC_LO, 8'h34);
    rd_chk(tcap_pkg::OFS_GRC_HI, 8'h12);
    $display("test capture done");
    // Mask, priority level and clear register on a pending flag
    wr(tcap_pkg::OFS_IEN, 8'h00);
    settle();
    chk_irq(1'b0);
    wr(tcap_pkg::OFS_IEN, 8'h05);
    settle();
    chk_irq(1'b1);
    wr(tcap_pkg::OFS_ILVL, 8'h00);
    settle();
    chk_irq(1'b0);
    wr(tcap_pkg::OFS_ILVL, 8'h10);
    wr(tcap_pkg::OFS_ICLR, 8'h01);
    rd_chk(tcap_pkg::OFS_STAT, 8'h00);
    chk_irq(1'b0);
    $display("test interrupt done");
    // Rising-only code ignores the falling edge
    wr(tcap_pkg::OFS_MODE, 8'h08);
    wr(tcap_pkg::OFS_IOR0, 8'h04);
    wr(tcap_pkg::OFS_CNT_LO, 8'h77);
    tcap_pulse_src_inst.drive_a(1'b1);
    settle();
    rd_chk(tcap_pkg::OFS_GRA_LO, 8'h77);
    wr(tcap_pkg::OFS_CNT_LO, 8'h88);
    tcap_pulse_src_inst.drive_a(1'b0);
    settle();
    rd_chk(tcap_pkg::OFS_GRA_LO, 8'h77);
    // Falling-only code ignores the rising edge; clear-select zeroes the counter
    wr(tcap_pkg::OFS_IOR0, 8'h05);
    wr(tcap_pkg::OFS_CCR1, 8'h80);
    wr(tcap_pkg::OFS_CNT_LO, 8'hAA);
    tcap_pulse_src_inst.drive_a(1'b1);
    settle();
    rd_chk(tcap_pkg::OFS_GRA_LO, 8'h77);
    wr(tcap_pkg::OFS_CNT_LO, 8'hBB);
    tcap_pulse_src_inst.drive_a(1'b0);
    settle();
    rd_chk(tcap_pkg::OFS_GRA_LO, 8'hBB);
    rd_chk(tcap_pkg::OFS_CNT_LO, 8'h00);
    wr(tcap_pkg::OFS_CCR1, 8'h00);
    // Channel C captures the counter itself
    wr(tcap_pkg::OFS_ICLR, 8'h85);
    wr(tcap_pkg::OFS_CNT_LO, 8'h99);
    tcap_pulse_src_inst.drive_c(1'b1);
    settle();
    rd_chk(tcap_pkg::OFS_GRC_LO, 8'h99);
    rd_chk(tcap_pkg::OFS_STAT, 8'h04);
    wr(tcap_pkg::OFS_IOR0, 8'h07);
    $display("test edges done");
    // Each broken setting suppresses capture
    for (int i = 0; i < 4; i++) begin
      wr(bad_a[i], bad_v[i]);
      wr(tcap_pkg::OFS_ICLR, 8'h85);
      tcap_pulse_src_inst.drive_a(~pin_a);
      settle();
      rd_chk(tcap_pkg::OFS_STAT, 8'h00);
      wr(bad_a[i], good_v[i]);
      settle();
    end
    $display("test refusals done");
    conclude();
  end
endmodule
